/* stm_top.v */
`timescale 1ns/1ps
`include "stm_defines.vh"

module stm_top #(
  parameter [31:0] CLK_HZ    = `STM_CLK_HZ,
  parameter [31:0] PAIR_CYC  = (`STM_CLK_HZ / 1000) * `STM_PAIR_WIN_MS,
  parameter [31:0] FAULT_CYC = (`STM_CLK_HZ / 1000) * `STM_FAULT_MS,
  parameter [15:0] RAMP_STEP = `STM_RAMP_STEP
) (
  // Clock and power-on reset.
  input  wire                    clk,
  input  wire                    rstn,
  // Enable channels from the safety controller, asynchronous pins.
  input  wire                    enable_channel_a,
  input  wire                    enable_channel_b,
  // Drive commands from the control logic, same clock.
  input  wire                    start_req,
  input  wire                    stop_req,
  input  wire [`STM_SPD_W-1:0]   test_speed_setpoint,
  // Drive state and safety indications.
  output reg                     torque_enable_r,
  output reg  [`STM_SPD_W-1:0]   speed_ref_r,
  output reg                     running_r,
  output reg                     trip_r,
  output reg                     channel_fault_r,
  output reg                     feedback_output_pos_r
);

  // Drive states, one-hot.
  // IDLE waits for a start with both channels present.
  // RUN ramps the speed reference up to the setpoint.
  // DECEL ramps it down under torque after an ordinary stop.
  // COAST has torque removed and holds the trip until a restart.
  // Any other code falls into COAST, so a corrupted state
  // can only ever remove torque, never apply it.
  localparam [3:0] ST_IDLE  = 4'h1;
  localparam [3:0] ST_RUN   = 4'h2;
  localparam [3:0] ST_DECEL = 4'h4;
  localparam [3:0] ST_COAST = 4'h8;
  localparam [31:0] CNT_MAX = 32'hffffffff;

  // Synchroniser stages, state, loss timer and pairing memory.
  // The loss timer saturates rather than wraps, so a very long
  // single-channel loss can never fold back below the fault
  // threshold and miss the latch.
  reg                   ch_a_meta_r;
  reg                   ch_a_r;
  reg                   ch_b_meta_r;
  reg                   ch_b_r;
  reg [3:0]             state_r;
  reg [3:0]             state_nxt;
  reg [`STM_CNT_W-1:0]  loss_cnt_r;
  reg [`STM_CNT_W-1:0]  loss_cnt_nxt;
  reg                   both_off_r;
  reg                   paired_r;
  reg                   paired_nxt;
  reg                   fault_nxt;
  reg                   trip_nxt;
  reg [`STM_SPD_W-1:0]  speed_nxt;

  // Channel summaries, all taken from the second synchroniser
  // stage only. Exactly one of the three is high at any time.
  // Only one_off advances the loss timer; both_off freezes it so
  // the pairing decision sees the gap between the two drops.
  wire both_on  = ch_a_r & ch_b_r;
  wire both_off = ~ch_a_r & ~ch_b_r;
  wire one_off  = ch_a_r ^ ch_b_r;

  // Two-stage synchronisers for the enable pins.
  // They reset to present: resetting them to absent would look
  // like a paired removal for two clocks after power-up and flash
  // the feedback output and the trip with healthy channels.
  // Channels that really are absent at power-up still show up
  // two clocks later as a paired removal, which is intended.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ch_a_meta_r <= 1'b1;
      ch_a_r      <= 1'b1;
      ch_b_meta_r <= 1'b1;
      ch_b_r      <= 1'b1;
    end else begin
      ch_a_meta_r <= enable_channel_a;
      ch_a_r      <= ch_a_meta_r;
      ch_b_meta_r <= enable_channel_b;
      ch_b_r      <= ch_b_meta_r;
    end
  end

  // Loss timer, pairing check and fault latch.
  // The timer counts clocks with exactly one channel absent and
  // clears once both are back. When the second channel drops, the
  // count so far decides whether the removal is a pair. The fault
  // sets on a long single loss and is never cleared here: only
  // the power-on reset takes it away.
  always @* begin
    loss_cnt_nxt = {`STM_CNT_W{1'b0}};
    paired_nxt   = 1'b0;
    fault_nxt    = channel_fault_r;
    if (one_off) begin
      if (loss_cnt_r != CNT_MAX) begin
        loss_cnt_nxt = loss_cnt_r + 32'h1;
      end else begin
        loss_cnt_nxt = loss_cnt_r;
      end
      if (loss_cnt_r >= FAULT_CYC) begin
        fault_nxt = 1'b1;
      end
    end else if (both_off) begin
      loss_cnt_nxt = loss_cnt_r;
      if (!both_off_r) begin
        paired_nxt = (loss_cnt_r <= PAIR_CYC);
      end else begin
        paired_nxt = paired_r;
      end
    end
  end

  // Drive sequencing, trip and speed reference.
  // Every state that can apply torque checks the channels and the
  // fault first, so a loss always wins over a stop or a ramp step.
  // A start is only taken with both channels present and no fault;
  // otherwise it is ignored and the trip stays reported.
  // The speed reference drops to zero whenever torque is removed,
  // so a restart ramps up again from rest.
  always @* begin
    state_nxt = state_r;
    trip_nxt  = trip_r;
    speed_nxt = speed_ref_r;
    case (state_r)
      ST_IDLE: begin
        speed_nxt = {`STM_SPD_W{1'b0}};
        if (!both_on) begin
          trip_nxt = 1'b1;
        end else if (start_req && !fault_nxt) begin
          trip_nxt  = 1'b0;
          state_nxt = ST_RUN;
        end
      end
      // Running: a channel loss coasts, a stop decelerates.
      ST_RUN: begin
        if (!both_on || fault_nxt) begin
          trip_nxt  = 1'b1;
          speed_nxt = {`STM_SPD_W{1'b0}};
          state_nxt = ST_COAST;
        end else if (stop_req) begin
          state_nxt = ST_DECEL;
        end else if (speed_ref_r + RAMP_STEP <= test_speed_setpoint) begin
          speed_nxt = speed_ref_r + RAMP_STEP;
        end else begin
          speed_nxt = test_speed_setpoint;
        end
      end
      // Controlled stop: ramp down one step per clock to rest.
      ST_DECEL: begin
        if (!both_on || fault_nxt) begin
          trip_nxt  = 1'b1;
          speed_nxt = {`STM_SPD_W{1'b0}};
          state_nxt = ST_COAST;
        end else if (speed_ref_r > RAMP_STEP) begin
          speed_nxt = speed_ref_r - RAMP_STEP;
        end else begin
          speed_nxt = {`STM_SPD_W{1'b0}};
          state_nxt = ST_IDLE;
        end
      end
      // Torque removed: the trip stands until a start is accepted
      // with both channels back and no latched fault.
      ST_COAST: begin
        speed_nxt = {`STM_SPD_W{1'b0}};
        trip_nxt  = 1'b1;
        if (both_on && !fault_nxt && start_req) begin
          trip_nxt  = 1'b0;
          state_nxt = ST_RUN;
        end else if (both_on && !fault_nxt) begin
          state_nxt = ST_COAST;
        end
      end
      default: begin
        trip_nxt  = 1'b1;
        speed_nxt = {`STM_SPD_W{1'b0}};
        state_nxt = ST_COAST;
      end
    endcase
  end

  // State registers; power-on reset is the only way out of a fault.
  // Every output is a flip-flop. Torque is computed from the next
  // state, feedback from the next pairing, both with the next fault
  // value, so neither can lag a loss by an extra clock.
  // Feedback needs a paired removal and no fault; it drops as soon
  // as either synchronised channel returns.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r               <= ST_IDLE;
      loss_cnt_r            <= {`STM_CNT_W{1'b0}};
      both_off_r            <= 1'b0;
      paired_r              <= 1'b0;
      channel_fault_r       <= 1'b0;
      trip_r                <= 1'b0;
      speed_ref_r           <= {`STM_SPD_W{1'b0}};
      running_r             <= 1'b0;
      torque_enable_r       <= 1'b0;
      feedback_output_pos_r <= 1'b0;
    end else begin
      state_r               <= state_nxt;
      loss_cnt_r            <= loss_cnt_nxt;
      both_off_r            <= both_off;
      paired_r              <= paired_nxt;
      channel_fault_r       <= fault_nxt;
      trip_r                <= trip_nxt | fault_nxt;
      speed_ref_r           <= speed_nxt;
      running_r             <= (state_nxt == ST_RUN);
      // Torque needs both channels and no latched fault.
      torque_enable_r       <= both_on & ~fault_nxt &
                               ((state_nxt == ST_RUN) |
                                (state_nxt == ST_DECEL));
      // Feedback only for a paired removal, never with a fault.
      feedback_output_pos_r <= both_off & paired_nxt & ~fault_nxt;
    end
  end

endmodule // stm_top

/* stm_defines.vh */
`ifndef STM_DEFINES_VH
`define STM_DEFINES_VH

// Clock rate in hertz.
`define STM_CLK_HZ        125000000
// Window in milliseconds within which both drops count as a pair.
`define STM_PAIR_WIN_MS   1000
// Single-channel loss in milliseconds beyond which a fault latches.
`define STM_FAULT_MS      3000
// Width of the loss counter.
`define STM_CNT_W         32
// Width of the speed setpoint and reference.
`define STM_SPD_W         16
// Speed reference change per clock while ramping.
`define STM_RAMP_STEP     16'h0001

`endif

/* stm_top_assertions.sv */
`timescale 1ns/1ps
module stm_top_chk (
  // Clock and reset.
  input wire        clk,
  input wire        rstn,
  // Inputs of the block.
  input wire        enable_channel_a,
  input wire        enable_channel_b,
  input wire        start_req,
  // Outputs of the block.
  input wire        torque_enable_r,
  input wire [15:0] speed_ref_r,
  input wire        running_r,
  input wire        trip_r,
  input wire        channel_fault_r,
  input wire        feedback_output_pos_r
);
  // Both channels present at the pins.
  wire ok = enable_channel_a && enable_channel_b;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_loss_trip: assert property (
    !ok |-> ##3 (trip_r && !torque_enable_r && !running_r))
    else $error("no trip after channel loss");
  a_fault_holds: assert property (
    channel_fault_r |=> channel_fault_r && trip_r && !running_r
    && !feedback_output_pos_r) else $error("latched fault not held");
  a_fb_paired: assert property (
    $rose(feedback_output_pos_r) |-> $past(!enable_channel_a
    && !enable_channel_b, 3)) else $error("feedback without both absent");
  a_fb_return: assert property (
    (enable_channel_a || enable_channel_b) |-> ##3 !feedback_output_pos_r)
    else $error("feedback on with a channel present");
  a_start_runs: assert property (
    start_req && ok && $past(ok) && $past(ok, 2) && $past(rstn, 3)
    && !torque_enable_r && !channel_fault_r |=> running_r && !trip_r)
    else $error("start refused with channels present");
  a_ramp_down: assert property (
    torque_enable_r && !running_r |=> speed_ref_r == 16'h0000
    || speed_ref_r == $past(speed_ref_r) - 16'h0001)
    else $error("stop not ramping down");
  a_run_no_fb: assert property (
    running_r |-> !feedback_output_pos_r) else $error("feedback while run");
  a_powerup: assert property (
    !$past(rstn) |-> !feedback_output_pos_r && !channel_fault_r)
    else $error("bad state at power-up");
endmodule // stm_top_chk
bind stm_top stm_top_chk u_chk (.clk, .rstn, .enable_channel_a,
  .enable_channel_b, .start_req, .torque_enable_r, .speed_ref_r, .running_r,
  .trip_r, .channel_fault_r, .feedback_output_pos_r);

/* stm_safety_ctrl.sv */
`timescale 1ns/1ps
module stm_safety_ctrl (
  // Demanded contact state, bit 1 channel A, bit 0 channel B.
  input wire [1:0] contacts,
  // Enable channels towards the drive.
  output wire      enable_channel_a,
  output wire      enable_channel_b
);
  // Closed contacts hold a channel active; opening both at once is allowed.
  assign enable_channel_a = contacts[1];
  assign enable_channel_b = contacts[0];
endmodule // stm_safety_ctrl

/* stm_top_tb.sv */
`timescale 1ns/1ps
module stm_top_tb;
  // Stimulus and observed signals.
  reg         clk, rstn, start_req, stop_req;
  reg  [1:0]  ch;
  wire        ena, enb, ten, run, trip, flt, fb;
  wire [15:0] sref;
  wire [2:0]  st = {run, trip, fb};
  integer     err_count, tests_run, i;
  stm_safety_ctrl u_ctl (.contacts(ch), .enable_channel_a(ena),
    .enable_channel_b(enb));
  stm_top #(.PAIR_CYC(100), .FAULT_CYC(300)) dut (.clk(clk), .rstn(rstn),
    .enable_channel_a(ena), .enable_channel_b(enb), .start_req(start_req),
    .stop_req(stop_req), .test_speed_setpoint(16'h0020),
    .torque_enable_r(ten), .speed_ref_r(sref), .running_r(run),
    .trip_r(trip), .channel_fault_r(flt), .feedback_output_pos_r(fb));
  // Free-running clock.
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  task chk(input [31:0] got, input [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge clk);
  endtask
  // Start pulse once the synchronisers have settled.
  task go;
    cyc(4);
    start_req = 1;
    cyc(1);
    start_req = 0;
  endtask
  task pwr;
    rstn = 0;
    ch = 3;
    cyc(2);
    rstn = 1;
    chk({flt, fb}, 0);
    cyc(2);
    chk({trip, fb}, 0);
    go;
    chk(st, 3'h4);
  endtask
  task short_loss(input [1:0] c);
    ch = c;
    cyc(4);
    chk({ten, trip, fb}, 3'h2);
    cyc(50);
    chk(fb, 0);
    ch = 3;
    go;
    chk(st, 3'h4);
  endtask
  task fault(input [1:0] c);
    ch = c;
    cyc(310);
    chk({flt, trip, fb}, 3'h6);
    ch = 3;
    go;
    chk(st, 3'h2);
    pwr;
  endtask
  task dual;
    ch = 2;
    cyc(20);
    ch = 0;
    cyc(4);
    chk(fb, 1);
    start_req = 1;
    cyc(1000);
    chk(st, 3'h3);
    start_req = 0;
    ch = 3;
    cyc(3);
    chk(fb, 0);
    go;
    chk(st, 3'h4);
  endtask
  task stp;
    cyc(40);
    chk(sref, 16'h0020);
    stop_req = 1;
    cyc(1);
    stop_req = 0;
    cyc(40);
    chk({ten, run, fb, sref}, 0);
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog against a hang.
  initial begin
    #100000;
    err_count = err_count + 1;
    end_sim;
  end
  // Main sequence of scenarios.
  initial begin
    err_count = 0;
    tests_run = 0;
    start_req = 0;
    stop_req = 0;
    pwr;
    for (i = 1; i < 3; i = i + 1) short_loss(i);
    for (i = 1; i < 3; i = i + 1) fault(i);
    dual;
    stp;
    end_sim;
  end
endmodule // stm_top_tb
